// ===== rtl/ecc_pkg.sv
// package: register map, field layout and constants of the enhanced capture/compare/pwm unit
package ecc_pkg;
  localparam int ADDR_W = 3;
  // register offsets
  localparam logic [2:0] OFF_VALUE_LOW  = 3'h0;
  localparam logic [2:0] OFF_VALUE_HIGH = 3'h1;
  localparam logic [2:0] OFF_UNIT_CTRL  = 3'h2;
  localparam logic [2:0] OFF_TMR_COUNT  = 3'h3;
  localparam logic [2:0] OFF_PER_LIMIT  = 3'h4;
  localparam logic [2:0] OFF_TMR_CTRL   = 3'h5;
  localparam logic [2:0] OFF_STATUS     = 3'h6;
  localparam logic [2:0] OFF_DELAY      = 3'h7;
  // reset values
  localparam logic [7:0] RST_UNIT_CTRL  = 8'h00;
  localparam logic [7:0] RST_TMR_COUNT  = 8'h00;
  localparam logic [7:0] RST_PER_LIMIT  = 8'hff;
  localparam logic [7:0] RST_TMR_CTRL   = 8'h00;
  localparam logic [7:0] RST_DELAY      = 8'h00;
  // period timer control fields
  localparam int TCTL_ON_BIT   = 2;
  localparam int TCTL_PRE_LSB  = 0;
  // status fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_TSEL_BIT = 1;
  // mode codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_RSV1     = 4'h1;
  localparam logic [3:0] MODE_CMP_TOG  = 4'h2;
  localparam logic [3:0] MODE_RSV3     = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_FLAG = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] PWM_SEL       = 2'h3;
  // output configurations
  localparam logic [1:0] CFG_SINGLE    = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD  = 2'h1;
  localparam logic [1:0] CFG_HALF      = 2'h2;
  localparam logic [1:0] CFG_FULL_REV  = 2'h3;
  // pins owned by the unit in each configuration (bit0 = a .. bit3 = d)
  localparam logic [3:0] OWN_ONE       = 4'h1;
  localparam logic [3:0] OWN_TWO       = 4'h3;
  localparam logic [3:0] OWN_FOUR      = 4'hf;
  // phase clocks per timer increment at prescale 1
  localparam int PHASES = 4;

  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } ecc_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } ecc_bus_t;

  typedef struct packed {
    logic pwm_out_d;
    logic pwm_out_c;
    logic pwm_out_b;
    logic pwm_out_a;
  } ecc_pins_t;
endpackage

// ===== rtl/ecc_unit.sv
// enhanced capture/compare/pwm unit with multi-output pwm steering
// Behaviour
// - writing mode 0000 stops capture, compare and pwm and resets internal state
// - modes 0001 and 0011 are reserved and do nothing
// - mode 0010 toggles the output and sets the event flag on each match
// - capture on falling, rising, every 4th or every 16th rising edge
// - mode 1000 drives output high, 1001 low on match, both set the flag
// - mode 1010 only sets the event flag on match
// - mode 1011 sets flag, clears the selected timer, starts a conversion if enabled
// - pwm modes; mode bit 1 inverts a and c, bit 0 inverts b and d
// - outside pwm the configuration is ignored; a is the capture/compare pin
// - configuration 00 modulates only a
// - configuration 01 modulates d, a active, b and c inactive
// - configuration 10 modulates a and b with dead band
// - configuration 11 modulates b, c active, a and d inactive
// - control bits 5:4 are the two low duty bits, unused outside pwm
// - the 16-bit value is two readable byte registers, both writable except the high byte in pwm modes
// - capture time base is timer one or timer three, chosen independently
// - the period tick is shared so the standard unit runs the same period
// - dual and quad configurations take port d pins from the parallel slave port
// - after timer equals limit: clear timer, set output unless duty zero, latch duty
// - output clears when latched duty equals timer with two fine bits (phase at prescale 1, else prescaler bits)
// - pwm control is double-buffered and loaded at the next period start
module ecc_unit (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire ecc_pkg::ecc_bus_t bus_i,
  output logic [7:0]            rdata_o,
  input  wire logic             capture_in_i,
  input  wire logic [15:0]      timer_one_i,
  input  wire logic [15:0]      timer_three_i,
  input  wire logic             adc_enabled_i,
  output ecc_pkg::ecc_pins_t    pins_o,
  output logic [3:0]            pin_owned_o,
  output logic                  unit_event_flag_o,
  output logic                  clear_timer_one_o,
  output logic                  clear_timer_three_o,
  output logic                  adc_start_o,
  output logic                  period_tick_o
);
  // registers
  logic [7:0]        value_low;
  logic [7:0]        value_high;
  ecc_pkg::ecc_ctrl_t ctrl;
  ecc_pkg::ecc_ctrl_t ctrl_act;
  logic [7:0]        period_timer_count;
  logic [7:0]        period_limit;
  logic [6:0]        period_timer_control;
  logic [7:0]        pwm_delay_setting;
  logic              flag;
  logic              tsel;
  // internal state
  logic [1:0]        phase;
  logic [3:0]        pre_cnt;
  logic [1:0]        duty_ext;
  logic              pwm_raw;
  logic              cmp_latch;
  logic              match_prev;
  logic              cap_prev;
  logic [3:0]        cap_cnt;
  logic [7:0]        db_cnt;
  logic              raw_prev;

  // bus decode
  wire wr_vlow  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_VALUE_LOW;
  wire wr_vhigh = bus_i.wr && bus_i.addr == ecc_pkg::OFF_VALUE_HIGH;
  wire wr_ctrl  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_UNIT_CTRL;
  wire wr_tcnt  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_TMR_COUNT;
  wire wr_plim  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_PER_LIMIT;
  wire wr_tctl  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_TMR_CTRL;
  wire wr_stat  = bus_i.wr && bus_i.addr == ecc_pkg::OFF_STATUS;
  wire wr_del   = bus_i.wr && bus_i.addr == ecc_pkg::OFF_DELAY;

  // mode classes from the written control value
  wire [3:0] mode      = ctrl.unit_mode_select;
  wire       wr_off    = wr_ctrl && bus_i.wdata[3:0] == ecc_pkg::MODE_OFF;
  wire       is_pwm    = mode[3:2] == ecc_pkg::PWM_SEL;
  wire       is_cap    = mode[3:2] == 2'h1;
  wire       is_cmp    = mode == ecc_pkg::MODE_CMP_TOG ||
                         (mode[3:2] == 2'h2);

  // period timer: prescale 1, 4 or 16 on the instruction rate
  wire       tmr_on    = period_timer_control[ecc_pkg::TCTL_ON_BIT];
  wire [1:0] pre_sel   = period_timer_control[ecc_pkg::TCTL_PRE_LSB +: 2];
  wire [3:0] pre_max   = pre_sel == 2'h0 ? 4'h0 : (pre_sel == 2'h1 ? 4'h3 : 4'hf);
  wire       q_last    = phase == 2'(ecc_pkg::PHASES - 1);
  wire       tmr_inc   = tmr_on && q_last && pre_cnt == pre_max;
  wire       per_end   = tmr_inc && period_timer_count == period_limit;
  wire [1:0] fine_bits = pre_sel == 2'h0 ? phase :
                         (pre_sel == 2'h1 ? pre_cnt[1:0] : pre_cnt[3:2]);
  wire       duty_zero = value_low == 8'h00 && ctrl.duty_low_bits == 2'h0;
  wire       duty_hit  = {value_high, duty_ext} == {period_timer_count, fine_bits};

  // capture and compare time base
  wire [15:0] tbase    = tsel ? timer_three_i : timer_one_i;
  wire        cap_rise = capture_in_i && !cap_prev;
  wire        cap_fall = !capture_in_i && cap_prev;
  wire [3:0]  cap_max  = mode == ecc_pkg::MODE_CAP_R4 ? 4'h3 :
                         (mode == ecc_pkg::MODE_CAP_R16 ? 4'hf : 4'h0);
  wire        cap_evt  = is_cap && ((mode == ecc_pkg::MODE_CAP_FALL) ? cap_fall :
                         (cap_rise && cap_cnt == cap_max));
  wire        match    = tbase == {value_high, value_low};
  wire        cmp_evt  = is_cmp && match && !match_prev;
  wire        evt      = cap_evt || cmp_evt;

  // pwm output relations, built from the buffered control
  wire       act_pwm   = ctrl_act.unit_mode_select[3:2] == ecc_pkg::PWM_SEL;
  wire       inv_ac    = ctrl_act.unit_mode_select[1];
  wire       inv_bd    = ctrl_act.unit_mode_select[0];
  wire [1:0] cfg       = ctrl_act.output_config_field;
  wire       db_idle   = db_cnt == 8'h00;
  logic [3:0] act_lvl;
  logic [3:0] own;

  function automatic logic [3:0] cfg_levels(input logic [1:0] c, input logic raw,
                                             input logic hb_a, input logic hb_b);
    unique case (c)
      ecc_pkg::CFG_SINGLE:   cfg_levels = {3'b000, raw};
      ecc_pkg::CFG_FULL_FWD: cfg_levels = {raw, 2'b00, 1'b1};
      ecc_pkg::CFG_HALF:     cfg_levels = {2'b00, hb_b, hb_a};
      ecc_pkg::CFG_FULL_REV: cfg_levels = {1'b0, 1'b1, raw, 1'b0};
    endcase
  endfunction

  // live pwm level: the duty match drops it in the same cycle, so the high time is exact
  wire pwm_live  = pwm_raw && !(duty_hit && tmr_on && !per_end);
  wire live_edge = pwm_live != raw_prev;
  // half bridge: complementary pair, both off while the dead band runs
  wire db_hold   = live_edge ? pwm_delay_setting != 8'h00 : !db_idle;
  wire hb_a = !db_hold && pwm_live;
  wire hb_b = !db_hold && !pwm_live;

  always_comb begin
    if (act_pwm) begin
      act_lvl = cfg_levels(cfg, pwm_live, hb_a, hb_b);
      own     = cfg == ecc_pkg::CFG_SINGLE ? ecc_pkg::OWN_ONE :
                (cfg == ecc_pkg::CFG_HALF ? ecc_pkg::OWN_TWO : ecc_pkg::OWN_FOUR);
    end else begin
      act_lvl = {3'b000, cmp_latch};
      own     = ecc_pkg::OWN_ONE;
    end
  end

  wire [3:0] next_pins = act_pwm ?
                         act_lvl ^ {inv_bd, inv_ac, inv_bd, inv_ac} : act_lvl;

  // register file
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      value_low            <= 8'h00;
      value_high           <= 8'h00;
      ctrl                 <= ecc_pkg::RST_UNIT_CTRL;
      period_limit         <= ecc_pkg::RST_PER_LIMIT;
      period_timer_control <= ecc_pkg::RST_TMR_CTRL[6:0];
      pwm_delay_setting    <= ecc_pkg::RST_DELAY;
      tsel                 <= 1'b0;
    end else begin
      if (cap_evt) begin
        {value_high, value_low} <= tbase;
      end else begin
        if (wr_vlow) value_low <= bus_i.wdata;
        if (wr_vhigh && !is_pwm) value_high <= bus_i.wdata;
        if (per_end && is_pwm) value_high <= value_low;
      end
      if (wr_ctrl) ctrl <= bus_i.wdata;
      if (wr_plim) period_limit <= bus_i.wdata;
      if (wr_tctl) period_timer_control <= bus_i.wdata[6:0];
      if (wr_del) pwm_delay_setting <= bus_i.wdata;
      if (wr_stat) tsel <= bus_i.wdata[ecc_pkg::STAT_TSEL_BIT];
    end
  end

  // event flag: a new event beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) flag <= 1'b0;
    else if (evt) flag <= 1'b1;
    else if (wr_stat && bus_i.wdata[ecc_pkg::STAT_FLAG_BIT]) flag <= 1'b0;
  end

  // period timer and phase divider
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase              <= 2'h0;
      pre_cnt            <= 4'h0;
      period_timer_count <= ecc_pkg::RST_TMR_COUNT;
    end else begin
      phase <= phase + 2'h1;
      if (wr_tctl) pre_cnt <= 4'h0;
      else if (tmr_on && q_last) pre_cnt <= (pre_cnt == pre_max) ? 4'h0 : pre_cnt + 4'h1;
      if (wr_tcnt) period_timer_count <= bus_i.wdata;
      else if (per_end) period_timer_count <= 8'h00;
      else if (tmr_inc) period_timer_count <= period_timer_count + 8'h01;
    end
  end

  // pwm core, buffered control and dead band
  always_ff @(posedge clk_i) begin
    if (reset_i || wr_off) begin
      pwm_raw  <= 1'b0;
      duty_ext <= 2'h0;
      ctrl_act <= ecc_pkg::RST_UNIT_CTRL;
      db_cnt   <= 8'h00;
      raw_prev <= 1'b0;
    end else begin
      if (per_end) begin
        ctrl_act <= ctrl;
        duty_ext <= ctrl.duty_low_bits;
        pwm_raw  <= is_pwm && !duty_zero;
      end else if (duty_hit && tmr_on) begin
        pwm_raw  <= 1'b0;
      end
      // non-pwm modes act at once, entering pwm waits for the period start
      if (!is_pwm) ctrl_act.unit_mode_select <= ctrl.unit_mode_select;
      raw_prev <= pwm_live;
      if (live_edge) begin
        db_cnt <= (pwm_delay_setting == 8'h00) ? 8'h00 : pwm_delay_setting - 8'h01;
      end else if (!db_idle) begin
        db_cnt <= db_cnt - 8'h01;
      end
    end
  end

  // capture and compare state
  always_ff @(posedge clk_i) begin
    if (reset_i || wr_off) begin
      cmp_latch  <= 1'b0;
      match_prev <= 1'b0;
      cap_prev   <= 1'b0;
      cap_cnt    <= 4'h0;
    end else begin
      cap_prev   <= capture_in_i;
      match_prev <= match && is_cmp;
      if (wr_ctrl) cap_cnt <= 4'h0;
      else if (is_cap && cap_rise) cap_cnt <= (cap_cnt == cap_max) ? 4'h0 : cap_cnt + 4'h1;
      if (cmp_evt) begin
        unique case (mode)
          ecc_pkg::MODE_CMP_TOG: cmp_latch <= !cmp_latch;
          ecc_pkg::MODE_CMP_SET: cmp_latch <= 1'b1;
          ecc_pkg::MODE_CMP_CLR: cmp_latch <= 1'b0;
          default:               cmp_latch <= cmp_latch;
        endcase
      end
    end
  end

  // outputs, all registered
  wire trig = cmp_evt && mode == ecc_pkg::MODE_CMP_TRIG;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pins_o              <= '0;
      pin_owned_o         <= ecc_pkg::OWN_ONE;
      unit_event_flag_o   <= 1'b0;
      clear_timer_one_o   <= 1'b0;
      clear_timer_three_o <= 1'b0;
      adc_start_o         <= 1'b0;
      period_tick_o       <= 1'b0;
      rdata_o             <= 8'h00;
    end else begin
      pins_o              <= next_pins;
      pin_owned_o         <= own;
      unit_event_flag_o   <= flag;
      clear_timer_one_o   <= trig && !tsel;
      clear_timer_three_o <= trig && tsel;
      adc_start_o         <= trig && adc_enabled_i;
      period_tick_o       <= per_end;
      if (bus_i.rd) begin
        unique case (bus_i.addr)
          ecc_pkg::OFF_VALUE_LOW:  rdata_o <= value_low;
          ecc_pkg::OFF_VALUE_HIGH: rdata_o <= value_high;
          ecc_pkg::OFF_UNIT_CTRL:  rdata_o <= ctrl;
          ecc_pkg::OFF_TMR_COUNT:  rdata_o <= period_timer_count;
          ecc_pkg::OFF_PER_LIMIT:  rdata_o <= period_limit;
          ecc_pkg::OFF_TMR_CTRL:   rdata_o <= {1'b0, period_timer_control};
          ecc_pkg::OFF_STATUS:     rdata_o <= {6'h00, tsel, flag};
          ecc_pkg::OFF_DELAY:      rdata_o <= pwm_delay_setting;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // checks
  a_off_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_off |=> !pwm_raw && !cmp_latch && cap_cnt == 4'h0)
    else $error("off mode did not reset state");
  a_reserved_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode == ecc_pkg::MODE_RSV1 || mode == ecc_pkg::MODE_RSV3) |-> !evt)
    else $error("reserved mode produced an event");
  a_toggle_out: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmp_evt && mode == ecc_pkg::MODE_CMP_TOG && !wr_ctrl) |=> cmp_latch != $past(cmp_latch)
    && flag)
    else $error("toggle compare failed");
  a_capture_val: assert property (@(posedge clk_i) disable iff (reset_i)
    cap_evt |=> {value_high, value_low} == $past(tbase) && flag)
    else $error("capture value not stored");
  a_set_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmp_evt && mode[3:1] == 3'h4 && !wr_ctrl) |=> cmp_latch == !$past(mode[0]))
    else $error("set or clear compare wrong");
  a_flag_only: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmp_evt && mode == ecc_pkg::MODE_CMP_FLAG && !wr_ctrl) |=> $stable(cmp_latch) && flag)
    else $error("flag-only compare moved output");
  a_trig_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
    trig |=> (clear_timer_one_o || clear_timer_three_o) && adc_start_o == $past(adc_enabled_i)
    ##1 !clear_timer_one_o && !clear_timer_three_o)
    else $error("special trigger pulse wrong");
  a_nonpwm_pins: assert property (@(posedge clk_i) disable iff (reset_i)
    !act_pwm |=> pin_owned_o == ecc_pkg::OWN_ONE && pins_o.pwm_out_a == $past(cmp_latch))
    else $error("capture/compare pin map wrong");
  a_period_end: assert property (@(posedge clk_i) disable iff (reset_i)
    (per_end && is_pwm && !wr_vhigh && !wr_tcnt && !wr_off) |=>
    period_timer_count == 8'h00 && value_high == $past(value_low) && period_tick_o)
    else $error("period end actions missing");
  a_duty_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (duty_hit && tmr_on && !per_end && !wr_off) |=> !pwm_raw)
    else $error("duty match did not clear output");
  a_quad_own: assert property (@(posedge clk_i) disable iff (reset_i)
    (act_pwm && cfg[0]) |=> pin_owned_o == ecc_pkg::OWN_FOUR)
    else $error("quad pins not owned");
  a_dead_band: assert property (@(posedge clk_i) disable iff (reset_i)
    (act_pwm && cfg == ecc_pkg::CFG_HALF) |=>
    !((pins_o.pwm_out_a ^ $past(inv_ac)) && (pins_o.pwm_out_b ^ $past(inv_bd))))
    else $error("half bridge pair both active");
  c_capture: cover property (@(posedge clk_i) cap_evt && mode == ecc_pkg::MODE_CAP_R16);
  c_trigger: cover property (@(posedge clk_i) trig && adc_enabled_i);
  c_full_rev: cover property (@(posedge clk_i) act_pwm && cfg == ecc_pkg::CFG_FULL_REV && per_end);
  c_half: cover property (@(posedge clk_i) act_pwm && cfg == ecc_pkg::CFG_HALF && !db_idle);
endmodule

// ===== dv/ecc_far_side.sv
// far-side model: the two capture/compare time bases that feed the unit
module ecc_far_side (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  input  wire logic   run_i,
  input  wire logic   restart_i,
  input  wire logic   clear_one_i,
  input  wire logic   clear_three_i,
  output logic [15:0] timer_one_o,
  output logic [15:0] timer_three_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // the two bases start apart so a capture shows which one was chosen
  always_ff @(posedge clk_i) begin
    if (reset_i || restart_i) begin
      timer_one_o   <= 16'h0000;
      timer_three_o <= 16'h8000;
    end else begin
      if (clear_one_i) timer_one_o <= 16'h0000;
      else if (run_i) timer_one_o <= timer_one_o + 16'h0001;
      if (clear_three_i) timer_three_o <= 16'h0000;
      else if (run_i) timer_three_o <= timer_three_o + 16'h0001;
    end
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the enhanced capture/compare/pwm unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i;
  logic               reset_i;
  ecc_pkg::ecc_bus_t  bus;
  logic [7:0]         rdata;
  logic               cap_in;
  logic [15:0]        t_one;
  logic [15:0]        t_three;
  logic               adc_en;
  ecc_pkg::ecc_pins_t pins;
  logic [3:0]         owned;
  logic               flag;
  logic               clr_one;
  logic               clr_three;
  logic               adc_start;
  logic               tick;
  logic               run;
  logic               restart;
  logic [7:0]         rd_val;
  logic               got;
  logic [15:0]        cnt [5];
  int                 miscompares;
  int                 n_tests;
  localparam logic [2:0] rw_addr [4] = '{ecc_pkg::OFF_VALUE_LOW, ecc_pkg::OFF_VALUE_HIGH,
                                         ecc_pkg::OFF_PER_LIMIT, ecc_pkg::OFF_DELAY};
  localparam logic [3:0] cmp_mode [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
  localparam logic       cmp_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  localparam int         cap_edges [4] = '{1, 1, 4, 16};
  localparam logic [3:0] own_exp [4] = '{ecc_pkg::OWN_ONE, ecc_pkg::OWN_FOUR,
                                         ecc_pkg::OWN_TWO, ecc_pkg::OWN_FOUR};

  ecc_unit i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
    .capture_in_i(cap_in), .timer_one_i(t_one), .timer_three_i(t_three),
    .adc_enabled_i(adc_en), .pins_o(pins), .pin_owned_o(owned), .unit_event_flag_o(flag),
    .clear_timer_one_o(clr_one), .clear_timer_three_o(clr_three),
    .adc_start_o(adc_start), .period_tick_o(tick));

  ecc_far_side i_far (
    .clk_i(clk_i), .reset_i(reset_i), .run_i(run), .restart_i(restart),
    .clear_one_i(clr_one), .clear_three_i(clr_three),
    .timer_one_o(t_one), .timer_three_o(t_three));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic kick;
    @(posedge clk_i);
    restart <= 1'b1;
    @(posedge clk_i);
    restart <= 1'b0;
  endtask

  task automatic wait_flag;
    got = 1'b0;
    repeat (100) begin
      cyc(1);
      if (flag === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cap_in <= 1'b1;
      repeat (3) @(posedge clk_i);
      cap_in <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    cyc(4);
  endtask

  // two pwm periods of 16 clocks each
  task automatic measure;
    cnt = '{default: 16'h0000};
    repeat (32) begin
      cyc(1);
      for (int p = 0; p < 4; p++) cnt[p] = cnt[p] + 16'(pins[p]);
      cnt[4] = cnt[4] + 16'(tick);
    end
  endtask

  // high clocks per window; mode polarity bits equal the configuration index
  function automatic logic [15:0] exp_cnt(input logic [1:0] cfg, input int p);
    logic [3:0]  modp;
    logic [3:0]  full;
    logic [15:0] base;
    modp = (cfg == 2'h1) ? 4'h8 : (cfg == 2'h3) ? 4'h2 : 4'h1;
    full = (cfg == 2'h1) ? 4'h1 : (cfg == 2'h3) ? 4'h4 : 4'h0;
    base = modp[p] ? 16'h0008 : full[p] ? 16'h0020 : 16'h0000;
    if (cfg == 2'h2 && p == 1) base = 16'h0018;
    return ((p % 2 == 0) ? cfg[1] : cfg[0]) ? 16'h0020 - base : base;
  endfunction

  initial begin
    #5_000_000;
    miscompares++;
    finish_test;
  end

  initial begin
    bus = '0;
    cap_in = 1'b0;
    adc_en = 1'b0;
    run = 1'b1;
    restart = 1'b0;
    reset_i = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    cyc(1);
    chk({owned, pins}, 8'h10);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk(rd_val, (a == 4) ? 8'hff : 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      wr(rw_addr[k], 8'h5a ^ 8'(k));
      rd(rw_addr[k]);
      chk(rd_val, 8'h5a ^ 8'(k));
    end
    wr(ecc_pkg::OFF_TMR_CTRL, 8'hf8);
    rd(ecc_pkg::OFF_TMR_CTRL);
    chk(rd_val, 8'h78);
    wr(ecc_pkg::OFF_VALUE_LOW, 8'h10);
    wr(ecc_pkg::OFF_VALUE_HIGH, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ecc_pkg::OFF_UNIT_CTRL, {4'h0, cmp_mode[k]});
      wr(ecc_pkg::OFF_STATUS, 8'h01);
      kick;
      wait_flag;
      chk(got, 1'b1);
      cyc(3);
      chk(pins.pwm_out_a, cmp_pin[k]);
    end
    wr(ecc_pkg::OFF_UNIT_CTRL, 8'h00);
    cyc(3);
    chk(pins, 4'h0);
    for (int k = 1; k < 4; k += 2) begin
      wr(ecc_pkg::OFF_UNIT_CTRL, 8'(k));
      wr(ecc_pkg::OFF_STATUS, 8'h01);
      kick;
      cyc(40);
      chk(flag, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      adc_en <= (k == 0);
      wr(ecc_pkg::OFF_VALUE_HIGH, k ? 8'h80 : 8'h00);
      wr(ecc_pkg::OFF_STATUS, {6'h00, k[0], 1'b1});
      wr(ecc_pkg::OFF_UNIT_CTRL, 8'h0b);
      kick;
      got = 1'b0;
      repeat (100) begin
        cyc(1);
        if (clr_one === 1'b1 || clr_three === 1'b1) begin
          got = 1'b1;
          break;
        end
      end
      chk({got, clr_one, clr_three, adc_start}, {1'b1, k == 0, k == 1, k == 0});
    end
    kick;
    cyc(37);
    run <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(ecc_pkg::OFF_UNIT_CTRL, {4'h0, 4'h4 + 4'(k)});
      wr(ecc_pkg::OFF_STATUS, {6'h00, k[0], 1'b1});
      pulse(cap_edges[k] - 1);
      chk(flag, 1'b0);
      pulse(1);
      chk(flag, 1'b1);
      rd(ecc_pkg::OFF_VALUE_LOW);
      chk(rd_val, k[0] ? t_three[7:0] : t_one[7:0]);
      rd(ecc_pkg::OFF_VALUE_HIGH);
      chk(rd_val, k[0] ? t_three[15:8] : t_one[15:8]);
    end
    run <= 1'b1;
    wr(ecc_pkg::OFF_DELAY, 8'h00);
    wr(ecc_pkg::OFF_PER_LIMIT, 8'h03);
    wr(ecc_pkg::OFF_VALUE_LOW, 8'h01);
    wr(ecc_pkg::OFF_TMR_CTRL, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(ecc_pkg::OFF_UNIT_CTRL, {2'(k), 2'b00, 2'b11, 2'(k)});
      cyc(48);
      measure;
      chk(owned, own_exp[k]);
      chk(cnt[4], 16'h0002);
      for (int p = 0; p < 4; p++)
        if (own_exp[k][p]) chk(cnt[p], exp_cnt(2'(k), p));
    end
    // half bridge with a two-clock dead band: each turn-on loses two clocks
    wr(ecc_pkg::OFF_DELAY, 8'h02);
    wr(ecc_pkg::OFF_UNIT_CTRL, 8'h8c);
    cyc(48);
    measure;
    chk(cnt[0], 16'h0004);
    chk(cnt[1], 16'h0014);
    wr(ecc_pkg::OFF_UNIT_CTRL, 8'h2c);
    cyc(48);
    measure;
    chk(cnt[0], 16'h000c);
    wr(ecc_pkg::OFF_VALUE_LOW, 8'h00);
    wr(ecc_pkg::OFF_UNIT_CTRL, 8'h0c);
    cyc(48);
    measure;
    chk(cnt[0], 16'h0000);
    finish_test;
  end
endmodule
